// ==== design/fpec_pkg.sv ====
/*
 Constants shared by the flash program/erase controller.
 Assumes a 25 MHz system clock and an 8-bit register write path.
*/
package fpec_pkg;
  localparam logic [7:0] FPEC_UNLOCK_KEY1 = 8'h73;
  localparam logic [7:0] FPEC_UNLOCK_KEY2 = 8'h8c;
  localparam logic [7:0] FPEC_CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] FPEC_CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] FPEC_CMD_LOCK = 8'h00;
  localparam int FPEC_ADDR_W = 16;
  localparam int FPEC_PAGE_LSB = 9;
  localparam int FPEC_PAGE_W = 7;
  localparam int FPEC_SECT_N = 8;
  localparam int FPEC_SECT_LSB = 4;
  localparam int FPEC_CLK_MHZ = 25;
  localparam int FPEC_PROG_NS = 40000;
  localparam int FPEC_PAGE_ERASE_NS = 400000;
  localparam int FPEC_MASS_ERASE_NS = 4000000;
  localparam int FPEC_PROG_CYC = FPEC_PROG_NS * FPEC_CLK_MHZ / 1000;
  localparam int FPEC_PAGE_ERASE_CYC = FPEC_PAGE_ERASE_NS * FPEC_CLK_MHZ / 1000;
  localparam int FPEC_MASS_ERASE_CYC = FPEC_MASS_ERASE_NS * FPEC_CLK_MHZ / 1000;
  localparam int FPEC_CNT_W = 24;
  localparam logic [FPEC_PAGE_W-1:0] FPEC_PAGE_RST = 7'h00;
  localparam logic [FPEC_SECT_N-1:0] FPEC_SECT_RST = 8'h00;
  typedef enum logic [1:0] {
    FPEC_LK_LOCKED = 2'b00,
    FPEC_LK_KEY1 = 2'b01,
    FPEC_LK_KEY2 = 2'b10,
    FPEC_LK_OPEN = 2'b11
  } fpec_lock_e;
  typedef enum logic [1:0] {
    FPEC_OP_IDLE = 2'b00,
    FPEC_OP_PROG = 2'b01,
    FPEC_OP_PERASE = 2'b10,
    FPEC_OP_MERASE = 2'b11
  } fpec_op_e;
endpackage

// ==== design/fpec_timer.sv ====
/*
 Operation timer: counts a loaded number of cycles and pulses when done.
 Assumes a load only while idle.
*/
`timescale 1ns/1ps
module fpec_timer
  import fpec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [FPEC_CNT_W-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  logic [FPEC_CNT_W-1:0] cnt_reg;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i && !busy_o) begin
        cnt_reg <= count_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_reg <= 24'h000001) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 24'h000001;
        end
      end
    end
  end
endmodule

// ==== design/fpec_ctrl.sv ====
/*
 Flash program/erase controller: unlock sequencing, protection checks,
 and program / page erase / mass erase control toward the flash array.
 Assumes register writes arrive as one-cycle strobes from core logic.
*/
// Notes on behaviour
// - Byte program, page erase and mass erase each run a timed array sequence.
// - Operations are refused by page lock, sector protect or write protect.
// - Nothing is programmed or erased while the controller is locked.
// - When unlocked, command writes start a page erase, or a mass erase under debug access.
// - Page erase acts only on the page held in the page register.
// - One unlock opens one page; outside debug access a new page needs a new unlock.
// - Debugger access ignores the write-protect option.
// - Debugger access ignores sector protection for program and erase.
// - Debugger access may program bytes outside the selected page.
// - Debugger access may clear sector protect bits as well as set them.
// - Debugger access unlocks without the second page write.
// - Debugger access may rewrite the page register while unlocked.
// - Debugger access accepts the mass erase command.
`timescale 1ns/1ps
module fpec_ctrl
  import fpec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic debug_i,
  input wire logic wr_protect_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic page_wr_i,
  input wire logic [FPEC_PAGE_W-1:0] page_data_i,
  input wire logic sect_wr_i,
  input wire logic [FPEC_SECT_N-1:0] sect_data_i,
  input wire logic prog_req_i,
  input wire logic [FPEC_ADDR_W-1:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  output logic unlocked_o,
  output logic busy_o,
  output logic refused_o,
  output logic [FPEC_PAGE_W-1:0] page_sel_o,
  output logic [FPEC_SECT_N-1:0] sect_prot_o,
  output logic flash_prog_o,
  output logic flash_page_erase_o,
  output logic flash_mass_erase_o,
  output logic [FPEC_ADDR_W-1:0] flash_addr_o,
  output logic [7:0] flash_data_o
);
  fpec_lock_e lock_reg;
  fpec_op_e op_reg;
  logic [FPEC_PAGE_W-1:0] page_reg;
  logic [FPEC_SECT_N-1:0] sect_reg;
  logic load;
  logic [FPEC_CNT_W-1:0] load_cnt;
  logic tmr_busy;
  logic tmr_done;
  logic prog_page_ok;
  logic prog_sect_ok;
  logic page_sect_ok;
  logic wp_ok;
  logic start_prog;
  logic start_perase;
  logic start_merase;
  logic idle;
  logic key2_seen_reg;
  logic confirm_ok;
  logic [FPEC_CNT_W-1:0] prog_len_reg;

  assign idle = (op_reg == FPEC_OP_IDLE);
  assign confirm_ok = page_wr_i && (lock_reg == FPEC_LK_KEY2) && key2_seen_reg &&
    (page_data_i == page_reg);
  assign wp_ok = debug_i || !wr_protect_i;
  assign prog_sect_ok = debug_i ||
    !sect_reg[prog_addr_i[FPEC_ADDR_W-1 -: 3]];
  assign page_sect_ok = debug_i || !sect_reg[page_reg[FPEC_PAGE_W-1 -: 3]];
  assign prog_page_ok = debug_i ||
    (prog_addr_i[FPEC_ADDR_W-1:FPEC_PAGE_LSB] == page_reg);
  assign start_prog = prog_req_i && idle && (lock_reg == FPEC_LK_OPEN) &&
    wp_ok && prog_sect_ok && prog_page_ok;
  assign start_perase = cmd_wr_i && idle && (lock_reg == FPEC_LK_OPEN) &&
    (cmd_data_i == FPEC_CMD_PAGE_ERASE) && wp_ok && page_sect_ok;
  assign start_merase = cmd_wr_i && idle && (lock_reg == FPEC_LK_OPEN) &&
    (cmd_data_i == FPEC_CMD_MASS_ERASE) && debug_i;
  assign load = start_prog || start_perase || start_merase;

  always_comb begin
    load_cnt = FPEC_PROG_CYC[FPEC_CNT_W-1:0];
    if (start_perase) begin
      load_cnt = FPEC_PAGE_ERASE_CYC[FPEC_CNT_W-1:0];
    end else if (start_merase) begin
      load_cnt = FPEC_MASS_ERASE_CYC[FPEC_CNT_W-1:0];
    end
  end

  fpec_timer u_timer (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .load_i(load),
    .count_i(load_cnt),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lock_reg <= FPEC_LK_LOCKED;
    end else if (cmd_wr_i && idle) begin
      case (lock_reg)
        FPEC_LK_LOCKED: begin
          lock_reg <= FPEC_LK_LOCKED;
        end
        FPEC_LK_KEY1: begin
          if (cmd_data_i == FPEC_UNLOCK_KEY1) begin
            lock_reg <= FPEC_LK_KEY2;
          end else begin
            lock_reg <= FPEC_LK_LOCKED;
          end
        end
        FPEC_LK_KEY2: begin
          // A repeated second key is out of order
          if (cmd_data_i == FPEC_UNLOCK_KEY2 && !key2_seen_reg) begin
            lock_reg <= debug_i ? FPEC_LK_OPEN : FPEC_LK_KEY2;
          end else begin
            lock_reg <= FPEC_LK_LOCKED;
          end
        end
        FPEC_LK_OPEN: begin
          if (cmd_data_i != FPEC_CMD_PAGE_ERASE && cmd_data_i != FPEC_CMD_MASS_ERASE) begin
            lock_reg <= FPEC_LK_LOCKED;
          end
        end
        default: begin
          lock_reg <= FPEC_LK_LOCKED;
        end
      endcase
    end else if (page_wr_i) begin
      case (lock_reg)
        FPEC_LK_LOCKED: begin
          lock_reg <= FPEC_LK_KEY1;
        end
        FPEC_LK_KEY2: begin
          // Both keys first, then the same page, or back to locked
          if (confirm_ok) begin
            lock_reg <= FPEC_LK_OPEN;
          end else begin
            lock_reg <= FPEC_LK_LOCKED;
          end
        end
        FPEC_LK_OPEN: begin
          if (!debug_i) begin
            lock_reg <= FPEC_LK_LOCKED;
          end
        end
        default: begin
          lock_reg <= FPEC_LK_KEY1;
        end
      endcase
    end
  end

  // Second key seen: held until the next command or page write, so the confirm may come later
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      key2_seen_reg <= 1'b0;
    end else if (cmd_wr_i && idle) begin
      key2_seen_reg <= (lock_reg == FPEC_LK_KEY2) && !key2_seen_reg &&
        (cmd_data_i == FPEC_UNLOCK_KEY2) && !debug_i;
    end else if (page_wr_i) begin
      key2_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      page_reg <= FPEC_PAGE_RST;
    end else if (page_wr_i && idle && (lock_reg != FPEC_LK_OPEN || debug_i)) begin
      page_reg <= page_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sect_reg <= FPEC_SECT_RST;
    end else if (sect_wr_i) begin
      sect_reg <= debug_i ? sect_data_i : (sect_reg | sect_data_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      op_reg <= FPEC_OP_IDLE;
      flash_addr_o <= '0;
      flash_data_o <= 8'h00;
    end else if (load) begin
      if (start_prog) begin
        op_reg <= FPEC_OP_PROG;
        flash_addr_o <= prog_addr_i;
        flash_data_o <= prog_data_i;
      end else if (start_perase) begin
        op_reg <= FPEC_OP_PERASE;
        flash_addr_o <= {page_reg, {FPEC_PAGE_LSB{1'b0}}};
      end else begin
        op_reg <= FPEC_OP_MERASE;
        flash_addr_o <= '0;
      end
    end else if (tmr_done) begin
      op_reg <= FPEC_OP_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flash_prog_o <= 1'b0;
      flash_page_erase_o <= 1'b0;
      flash_mass_erase_o <= 1'b0;
      busy_o <= 1'b0;
      refused_o <= 1'b0;
      unlocked_o <= 1'b0;
      page_sel_o <= FPEC_PAGE_RST;
      sect_prot_o <= FPEC_SECT_RST;
    end else begin
      flash_prog_o <= (op_reg == FPEC_OP_PROG) && tmr_busy;
      flash_page_erase_o <= (op_reg == FPEC_OP_PERASE) && tmr_busy;
      flash_mass_erase_o <= (op_reg == FPEC_OP_MERASE) && tmr_busy;
      busy_o <= !idle;
      refused_o <= prog_req_i && !start_prog;
      unlocked_o <= (lock_reg == FPEC_LK_OPEN);
      page_sel_o <= page_reg;
      sect_prot_o <= sect_reg;
    end
  end

  // Strobe length count, kept only for the length check below
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prog_len_reg <= '0;
    end else if (flash_prog_o) begin
      prog_len_reg <= prog_len_reg + 24'h000001;
    end else begin
      prog_len_reg <= '0;
    end
  end

  a_locked_no_prog: assert property (@(posedge core_clk_i) disable iff (reset_i)
    idle && lock_reg != FPEC_LK_OPEN |=> idle)
    else $error("Operation started while locked");
  a_refuse_locked: assert property (@(posedge core_clk_i) disable iff (reset_i)
    prog_req_i && lock_reg != FPEC_LK_OPEN |=> refused_o)
    else $error("Locked program not refused");
  a_confirm_opens: assert property (@(posedge core_clk_i) disable iff (reset_i)
    confirm_ok && !cmd_wr_i |-> ##2 unlocked_o)
    else $error("Confirming page write did not unlock");
  a_mass_needs_dbg: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(flash_mass_erase_o) |-> $past(debug_i, 2))
    else $error("Mass erase outside debug");
  a_sect_set_only: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !debug_i && sect_wr_i |=> ((sect_reg & $past(sect_reg)) == $past(sect_reg)))
    else $error("Sector bit cleared outside debug");
  a_page_erase_addr: assert property (@(posedge core_clk_i) disable iff (reset_i)
    start_perase |=> flash_addr_o[FPEC_ADDR_W-1:FPEC_PAGE_LSB] == $past(page_reg))
    else $error("Page erase on wrong page");
  a_prog_in_page: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(flash_prog_o) && !$past(debug_i, 2)
    |-> flash_addr_o[FPEC_ADDR_W-1:FPEC_PAGE_LSB] == $past(page_reg, 2))
    else $error("Program outside page");
  a_wp_blocks: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr_protect_i && !debug_i && idle |=> idle)
    else $error("Write protect bypassed");
  a_bad_key_locks: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cmd_wr_i && idle && lock_reg == FPEC_LK_KEY1 && cmd_data_i != FPEC_UNLOCK_KEY1
    |=> lock_reg == FPEC_LK_LOCKED)
    else $error("Wrong key did not relock");
  a_new_page_locks: assert property (@(posedge core_clk_i) disable iff (reset_i)
    page_wr_i && !cmd_wr_i && !debug_i && lock_reg == FPEC_LK_OPEN
    |=> lock_reg == FPEC_LK_LOCKED)
    else $error("Second page opened without unlock");
  a_prog_strobe: assert property (@(posedge core_clk_i) disable iff (reset_i)
    start_prog |-> ##2 flash_prog_o)
    else $error("Program strobe missing");
  a_prog_length: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(flash_prog_o) && !$past(reset_i) |-> prog_len_reg == FPEC_PROG_CYC[FPEC_CNT_W-1:0])
    else $error("Program strobe length wrong");
  c_prog: cover property (@(posedge core_clk_i) start_prog);
  c_perase: cover property (@(posedge core_clk_i) start_perase);
  c_merase: cover property (@(posedge core_clk_i) start_merase);
  c_confirm: cover property (@(posedge core_clk_i) confirm_ok);
  c_refused: cover property (@(posedge core_clk_i) refused_o);
endmodule

// ==== tb/fpec_flash_model.sv ====
/*
 Behavioural flash array: applies program and erase strobes to a byte store.
 Assumes address and data from the controller are valid when a strobe rises.
*/
`timescale 1ns/1ps
module fpec_flash_model
  import fpec_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic prog_i,
  input wire logic page_erase_i,
  input wire logic mass_erase_i,
  input wire logic [FPEC_ADDR_W-1:0] addr_i,
  input wire logic [7:0] data_i
);
  logic [7:0] mem [0:65535];
  logic prog_reg = 1'b0;
  logic pe_reg = 1'b0;
  logic me_reg = 1'b0;
  // Starts all zero so that any erase shows up
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  function automatic logic [7:0] peek(input logic [15:0] a);
    return mem[a];
  endfunction
  always @(posedge core_clk_i) begin
    prog_reg <= prog_i;
    pe_reg <= page_erase_i;
    me_reg <= mass_erase_i;
    // Cells only clear bits when programmed
    if (prog_i && !prog_reg) mem[addr_i] <= mem[addr_i] & data_i;
    if (page_erase_i && !pe_reg) begin
      for (int i = 0; i < 512; i++) mem[{addr_i[15:9], i[8:0]}] <= 8'hff;
    end
    if (mass_erase_i && !me_reg) begin
      foreach (mem[i]) mem[i] <= 8'hff;
    end
  end
endmodule

// ==== tb/fpec_ctrl_tb_top.sv ====
/*
 Testbench for the flash program/erase controller, strobe-driven.
 Assumes the flash model beside it and the package timing constants.
*/
`timescale 1ns/1ps
module fpec_ctrl_tb_top
  import fpec_pkg::*;
;
  logic clk = 0, rst = 1, dbg = 0, wp = 0, cmd_wr = 0, page_wr = 0, sect_wr = 0, prog_req = 0;
  logic [7:0] cmd_d = 8'h00, sect_d = 8'h00, prog_d = 8'h00, f_data;
  logic [6:0] page_d = 7'h00, page_sel;
  logic [15:0] prog_a = 16'h0000, f_addr;
  logic [7:0] sect_prot;
  logic unlocked, busy, refused, f_prog, f_pe, f_me;
  int num_errors = 0, tests_run = 0;
  fpec_ctrl dut_u (.core_clk_i(clk), .reset_i(rst), .debug_i(dbg), .wr_protect_i(wp),
    .cmd_wr_i(cmd_wr), .cmd_data_i(cmd_d), .page_wr_i(page_wr), .page_data_i(page_d),
    .sect_wr_i(sect_wr), .sect_data_i(sect_d), .prog_req_i(prog_req), .prog_addr_i(prog_a),
    .prog_data_i(prog_d), .unlocked_o(unlocked), .busy_o(busy), .refused_o(refused),
    .page_sel_o(page_sel), .sect_prot_o(sect_prot), .flash_prog_o(f_prog),
    .flash_page_erase_o(f_pe), .flash_mass_erase_o(f_me), .flash_addr_o(f_addr),
    .flash_data_o(f_data));
  fpec_flash_model mem_u (.core_clk_i(clk), .prog_i(f_prog), .page_erase_i(f_pe),
    .mass_erase_i(f_me), .addr_i(f_addr), .data_i(f_data));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  // One-cycle strobe: 0 command, 1 page, 2 sector, 3 program
  task automatic strobe(input int k, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    case (k)
      0: begin cmd_wr = 1; cmd_d = d; end
      1: begin page_wr = 1; page_d = a[6:0]; end
      2: begin sect_wr = 1; sect_d = d; end
      default: begin prog_req = 1; prog_a = a; prog_d = d; end
    endcase
    @(posedge clk);
    #1;
    {cmd_wr, page_wr, sect_wr, prog_req} = 4'h0;
  endtask
  task automatic seen(ref logic s, input int n, output bit hit);
    hit = 0;
    repeat (n) begin
      @(posedge clk);
      if (s === 1'b1) hit = 1;
    end
    // Leave the edge so that callers drive off it
    #1;
  endtask
  task automatic idle_wait();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 110000) begin
      @(posedge clk);
      n++;
    end
    chk(busy === 1'b0, "operation never finished");
  endtask
  // Lock first so every unlock starts from a clean state
  task automatic unlock(input logic [6:0] p, input bit exp);
    bit hit;
    strobe(0, 16'h0, FPEC_CMD_LOCK);
    strobe(1, {9'h0, p}, 8'h00);
    strobe(0, 16'h0, FPEC_UNLOCK_KEY1);
    strobe(0, 16'h0, FPEC_UNLOCK_KEY2);
    if (!dbg) strobe(1, {9'h0, p}, 8'h00);
    seen(unlocked, 4, hit);
    chk(hit == exp, "unlock state wrong");
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d, input bit ok);
    bit hit;
    logic [7:0] exp;
    exp = mem_u.peek(a) & d;
    strobe(3, a, d);
    if (ok) begin
      seen(f_prog, 4, hit);
      chk(hit, "program strobe missing");
      idle_wait();
      chk(mem_u.peek(a) === exp, "programmed byte wrong");
    end else begin
      seen(refused, 4, hit);
      chk(hit && f_prog === 1'b0, "program not refused");
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    bit hit;
    repeat (4) @(posedge clk);
    #1 rst = 0;
    chk(unlocked === 1'b0 && busy === 1'b0, "not idle after reset");
    prog(16'h0a10, 8'h5a, 0);
    unlock(7'd5, 1);
    strobe(0, 16'h0, FPEC_CMD_PAGE_ERASE);
    seen(f_pe, 4, hit);
    chk(hit, "page erase not started");
    idle_wait();
    chk(mem_u.peek(16'h0a00) === 8'hff && mem_u.peek(16'h0bff) === 8'hff, "page not erased");
    chk(mem_u.peek(16'h0c00) === 8'h00 && mem_u.peek(16'h09ff) === 8'h00, "neighbour hit");
    unlock(7'd5, 1);
    prog(16'h0a10, 8'h5a, 1);
    prog(16'h0c10, 8'h33, 0);
    strobe(1, 16'h6, 8'h00);
    seen(unlocked, 2, hit);
    chk(unlocked === 1'b0 && page_sel === 7'd5, "second page opened");
    strobe(0, 16'h0, FPEC_CMD_LOCK);
    strobe(1, 16'h5, 8'h00);
    strobe(0, 16'h0, FPEC_UNLOCK_KEY1);
    strobe(0, 16'h0, 8'h11);
    strobe(1, 16'h5, 8'h00);
    chk(unlocked === 1'b0, "wrong key unlocked");
    strobe(0, 16'h0, FPEC_CMD_LOCK);
    strobe(1, 16'h5, 8'h00);
    strobe(0, 16'h0, FPEC_UNLOCK_KEY1);
    strobe(0, 16'h0, FPEC_UNLOCK_KEY2);
    strobe(1, 16'h6, 8'h00);
    seen(unlocked, 4, hit);
    chk(!hit, "unlocked with another page");
    prog(16'h0a11, 8'h0f, 0);
    unlock(7'd5, 1);
    strobe(0, 16'h0, FPEC_CMD_MASS_ERASE);
    seen(f_me, 5, hit);
    chk(!hit, "mass erase outside debug");
    wp = 1;
    unlock(7'd5, 1);
    prog(16'h0a20, 8'ha5, 0);
    wp = 0;
    strobe(2, 16'h0, 8'h01);
    seen(sect_wr, 2, hit);
    chk(sect_prot === 8'h01, "sector bit not set");
    unlock(7'd5, 1);
    prog(16'h0a21, 8'ha5, 0);
    strobe(2, 16'h0, 8'h00);
    seen(sect_wr, 2, hit);
    chk(sect_prot === 8'h01, "sector bit cleared outside debug");
    // Debug relaxes protection, so write protect stays on here
    dbg = 1;
    wp = 1;
    unlock(7'd5, 1);
    prog(16'h0a30, 8'hc3, 1);
    prog(16'h1210, 8'h0f, 1);
    strobe(1, 16'h9, 8'h00);
    seen(sect_wr, 2, hit);
    chk(page_sel === 7'd9, "page select not rewritten");
    strobe(2, 16'h0, 8'h00);
    seen(sect_wr, 2, hit);
    chk(sect_prot === 8'h00, "sector bit not cleared");
    strobe(0, 16'h0, FPEC_CMD_MASS_ERASE);
    seen(f_me, 4, hit);
    chk(hit, "mass erase refused in debug");
    // Reset cuts the long mass erase short to keep the run brief
    rst = 1;
    repeat (2) @(posedge clk);
    #1;
    chk(f_me === 1'b0 && busy === 1'b0, "reset did not stop erase");
    print_verdict();
  end
endmodule
